/* src/acsr_regs.vh */
`ifndef ACSR_REGS_VH
`define ACSR_REGS_VH

// ==========================================
// register offsets on the register port
`define ACSR_OFF_IDENT 6'h0f
`define ACSR_OFF_CTRL2 6'h21
`define ACSR_OFF_CTRL3 6'h22
`define ACSR_OFF_DC_RELOAD 6'h23
`define ACSR_OFF_STATUS 6'h27
`define ACSR_OFF_X_SAMPLE 6'h29
`define ACSR_OFF_Y_SAMPLE 6'h2b
`define ACSR_OFF_Z_SAMPLE 6'h2d
`define ACSR_OFF_EVT1_SRC 6'h31
`define ACSR_OFF_EVT2_SRC 6'h35

// ==========================================
// control_two fields
`define ACSR_C2_THREE_WIRE 7
`define ACSR_C2_RELOAD 6
`define ACSR_C2_OUT_FILTER 4
`define ACSR_C2_EVT2_FILTER 3
`define ACSR_C2_EVT1_FILTER 2
`define ACSR_C2_CUTOFF_HI 1
`define ACSR_C2_CUTOFF_LO 0

// ==========================================
// control_three fields
`define ACSR_C3_POLARITY 7
`define ACSR_C3_DRIVE 6
`define ACSR_C3_PIN2_HI 5
`define ACSR_C3_PIN2_LO 3
`define ACSR_C3_PIN1_HI 2
`define ACSR_C3_PIN1_LO 0

// ==========================================
// reset values
`define ACSR_CTRL2_RST 8'h00
`define ACSR_CTRL3_RST 8'h00

// ==========================================
// interrupt routing codes
`define ACSR_ROUTE_GND 3'h0
`define ACSR_ROUTE_EVT1 3'h1
`define ACSR_ROUTE_EVT2 3'h2
`define ACSR_ROUTE_EITHER 3'h3
`define ACSR_ROUTE_READY 3'h4

// ==========================================
// timing: clock period and sample periods in ns
`define ACSR_CLK_NS 20
`define ACSR_SLOW_PERIOD_NS 10000000
`define ACSR_FAST_PERIOD_NS 2500000

// high-pass corner at code 00, in mHz
`define ACSR_CORNER_SLOW_MHZ 14'h07d0
`define ACSR_CORNER_FAST_MHZ 14'h1f40

`endif

/* src/acsr_axis_flags.v */
`timescale 1ns/10ps
`default_nettype none

// per-axis data-available and overrun flags
module acsr_axis_flags (
	// clock and reset
	input wire clk,
	input wire rst,
	// sample events
	input wire axis_enable,
	input wire sample_tick,
	input wire read_clr,
	// flags
	output reg avail_r,
	output reg overrun_r
);

// ==========================================
// flag update
wire new_sample;
reg avail_nxt;
reg overrun_nxt;

// disabled axis never sees a new sample
assign new_sample = sample_tick & axis_enable;

// a sample arriving with the read wins over the clear
always @* begin
	avail_nxt = new_sample | (avail_r & ~read_clr);
	overrun_nxt = (new_sample & avail_r) | (overrun_r & ~read_clr);
end

always @(posedge clk) begin
	if (rst) begin
		avail_r <= 1'b0;
		overrun_r <= 1'b0;
	end else begin
		avail_r <= avail_nxt;
		overrun_r <= overrun_nxt;
	end
end

endmodule
`default_nettype wire

/* src/acsr_irq_pin.v */
`timescale 1ns/10ps
`default_nettype none
`include "acsr_regs.vh"

// one interrupt pin: routing, polarity, drive type
module acsr_irq_pin (
	// clock and reset
	input wire clk,
	input wire rst,
	// configuration
	input wire [2:0] route,
	input wire polarity,
	input wire drive_type,
	// interrupt sources
	input wire evt_one,
	input wire evt_two,
	input wire data_ready,
	// pin
	output reg pin_out_r,
	output reg pin_oe_r
);

// ==========================================
// source select
reg active;
always @* begin
	case (route)
	`ACSR_ROUTE_GND: active = 1'b0;
	`ACSR_ROUTE_EVT1: active = evt_one;
	`ACSR_ROUTE_EVT2: active = evt_two;
	`ACSR_ROUTE_EITHER: active = evt_one | evt_two;
	`ACSR_ROUTE_READY: active = data_ready;
	default: active = 1'b0;
	endcase
end

// ==========================================
// pad drive; open drain releases when idle so a wired-or line works
// ground route pulls low whatever polarity and drive type say
wire tie_low;
assign tie_low = (route == `ACSR_ROUTE_GND);

always @(posedge clk) begin
	if (rst) begin
		pin_out_r <= 1'b0;
		pin_oe_r <= 1'b1;
	end else begin
		pin_out_r <= ~tie_low & (active ^ polarity);
		pin_oe_r <= tie_low | ~drive_type | active;
	end
end

endmodule
`default_nettype wire

/* src/acsr_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "acsr_regs.vh"

module acsr_top #(
	parameter SLOW_CYCLES = `ACSR_SLOW_PERIOD_NS / `ACSR_CLK_NS,
	parameter FAST_CYCLES = `ACSR_FAST_PERIOD_NS / `ACSR_CLK_NS,
	parameter CNT_W = 20,
	parameter [7:0] IDENT_CODE = 8'h5a // arbitrary identifier value
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// register port
	input wire [5:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	output reg reg_rvalid_r,
	// control one fields kept outside
	input wire sample_rate_sel,
	input wire x_en,
	input wire y_en,
	input wire z_en,
	// sample inputs, raw and high-pass filtered
	input wire [7:0] raw_x,
	input wire [7:0] raw_y,
	input wire [7:0] raw_z,
	input wire [7:0] hp_x,
	input wire [7:0] hp_y,
	input wire [7:0] hp_z,
	// event generators
	input wire [7:0] event1_flags,
	input wire [7:0] event2_flags,
	input wire event_gen_one,
	input wire event_gen_two,
	output reg event1_filter_enable_r,
	output reg event2_filter_enable_r,
	// high-pass filter control
	output reg [1:0] cutoff_code_r,
	output reg [13:0] hp_corner_mhz_r,
	output reg filter_dc_reload_r,
	// trim reload
	output reg trim_reload_r,
	input wire trim_reload_done,
	// sample timing
	output reg sample_tick_r,
	// serial read data path
	input wire ser_out_bit,
	input wire ser_out_active,
	output reg sdo_out_r,
	output reg sdo_oe_r,
	output reg sda_out_r,
	output reg sda_oe_r,
	// interrupt pins
	output wire irq_pin_one_out,
	output wire irq_pin_one_oe,
	output wire irq_pin_two_out,
	output wire irq_pin_two_oe
);

// ==========================================
// control registers
reg three_wire_select_r;
reg output_filter_select_r;
reg irq_polarity_r;
reg irq_drive_type_r;
reg [2:0] pin1_route_r;
reg [2:0] pin2_route_r;

wire wr_ctrl2;
wire wr_ctrl3;
assign wr_ctrl2 = reg_wr & (reg_addr == `ACSR_OFF_CTRL2);
assign wr_ctrl3 = reg_wr & (reg_addr == `ACSR_OFF_CTRL3);

// control two and three; all fields clear at reset
always @(posedge clk) begin
	if (rst) begin
		three_wire_select_r <= 1'b0;
		output_filter_select_r <= 1'b0;
		event1_filter_enable_r <= 1'b0;
		event2_filter_enable_r <= 1'b0;
		cutoff_code_r <= 2'h0;
		irq_polarity_r <= 1'b0;
		irq_drive_type_r <= 1'b0;
		pin1_route_r <= 3'h0;
		pin2_route_r <= 3'h0;
	end else begin
		if (wr_ctrl2) begin
			three_wire_select_r <= reg_wdata[`ACSR_C2_THREE_WIRE];
			output_filter_select_r <= reg_wdata[`ACSR_C2_OUT_FILTER];
			event1_filter_enable_r <= reg_wdata[`ACSR_C2_EVT1_FILTER];
			event2_filter_enable_r <= reg_wdata[`ACSR_C2_EVT2_FILTER];
			cutoff_code_r <=
				reg_wdata[`ACSR_C2_CUTOFF_HI:`ACSR_C2_CUTOFF_LO];
		end
		if (wr_ctrl3) begin
			irq_polarity_r <= reg_wdata[`ACSR_C3_POLARITY];
			irq_drive_type_r <= reg_wdata[`ACSR_C3_DRIVE];
			pin2_route_r <= reg_wdata[`ACSR_C3_PIN2_HI:`ACSR_C3_PIN2_LO];
			pin1_route_r <= reg_wdata[`ACSR_C3_PIN1_HI:`ACSR_C3_PIN1_LO];
		end
	end
end

// ==========================================
// trim reload bit
// a reload in flight cannot be aborted by writing zero
reg trim_reload_nxt;
always @* begin
	trim_reload_nxt = trim_reload_r & ~trim_reload_done;
	if (wr_ctrl2 && reg_wdata[`ACSR_C2_RELOAD])
		trim_reload_nxt = 1'b1;
end

always @(posedge clk) begin
	if (rst)
		trim_reload_r <= 1'b0;
	else
		trim_reload_r <= trim_reload_nxt;
end

// ==========================================
// high-pass corner, halved per code step, times four at the fast rate
always @(posedge clk) begin
	if (rst) begin
		hp_corner_mhz_r <= `ACSR_CORNER_SLOW_MHZ;
	end else if (sample_rate_sel) begin
		hp_corner_mhz_r <= `ACSR_CORNER_FAST_MHZ >> cutoff_code_r;
	end else begin
		hp_corner_mhz_r <= `ACSR_CORNER_SLOW_MHZ >> cutoff_code_r;
	end
end

// ==========================================
// sample tick generator
// >= compare lets a fast switch cut the current slow period short
reg [CNT_W-1:0] rate_cnt_r;
wire [CNT_W-1:0] period_last;
wire period_done;

assign period_last = sample_rate_sel ?
	FAST_CYCLES[CNT_W-1:0] - 1'b1 : SLOW_CYCLES[CNT_W-1:0] - 1'b1;
assign period_done = (rate_cnt_r >= period_last);

always @(posedge clk) begin
	if (rst) begin
		rate_cnt_r <= {CNT_W{1'b0}};
		sample_tick_r <= 1'b0;
	end else begin
		sample_tick_r <= period_done;
		if (period_done)
			rate_cnt_r <= {CNT_W{1'b0}};
		else
			rate_cnt_r <= rate_cnt_r + 1'b1;
	end
end

// ==========================================
// output sample registers
reg [7:0] x_sample_r;
reg [7:0] y_sample_r;
reg [7:0] z_sample_r;

// filtered or bypassed path chosen at capture time
always @(posedge clk) begin
	if (rst) begin
		x_sample_r <= 8'h00;
		y_sample_r <= 8'h00;
		z_sample_r <= 8'h00;
	end else if (sample_tick_r) begin
		if (x_en)
			x_sample_r <= output_filter_select_r ? hp_x : raw_x;
		if (y_en)
			y_sample_r <= output_filter_select_r ? hp_y : raw_y;
		if (z_en)
			z_sample_r <= output_filter_select_r ? hp_z : raw_z;
	end
end

// ==========================================
// event source registers follow their own generator
reg [7:0] event1_source_r;
reg [7:0] event2_source_r;
always @(posedge clk) begin
	if (rst) begin
		event1_source_r <= 8'h00;
		event2_source_r <= 8'h00;
	end else begin
		event1_source_r <= event1_flags;
		event2_source_r <= event2_flags;
	end
end

// ==========================================
// per-axis status flags
wire rd_x;
wire rd_y;
wire rd_z;
wire x_avail;
wire y_avail;
wire z_avail;
wire x_overrun;
wire y_overrun;
wire z_overrun;

assign rd_x = reg_rd & (reg_addr == `ACSR_OFF_X_SAMPLE);
assign rd_y = reg_rd & (reg_addr == `ACSR_OFF_Y_SAMPLE);
assign rd_z = reg_rd & (reg_addr == `ACSR_OFF_Z_SAMPLE);

acsr_axis_flags u_x_flags (
	.clk(clk),
	.rst(rst),
	.axis_enable(x_en),
	.sample_tick(sample_tick_r),
	.read_clr(rd_x),
	.avail_r(x_avail),
	.overrun_r(x_overrun)
);

acsr_axis_flags u_y_flags (
	.clk(clk),
	.rst(rst),
	.axis_enable(y_en),
	.sample_tick(sample_tick_r),
	.read_clr(rd_y),
	.avail_r(y_avail),
	.overrun_r(y_overrun)
);

acsr_axis_flags u_z_flags (
	.clk(clk),
	.rst(rst),
	.axis_enable(z_en),
	.sample_tick(sample_tick_r),
	.read_clr(rd_z),
	.avail_r(z_avail),
	.overrun_r(z_overrun)
);

// ==========================================
// all-axes flags
// they stay up until no enabled axis still holds unread data
reg all_axes_avail_r;
reg all_axes_overrun_r;
wire any_en;
wire unread_left;
wire set_tick;

assign any_en = x_en | y_en | z_en;
assign set_tick = sample_tick_r & any_en;
assign unread_left = (x_en & x_avail) | (y_en & y_avail) |
	(z_en & z_avail);

always @(posedge clk) begin
	if (rst) begin
		all_axes_avail_r <= 1'b0;
		all_axes_overrun_r <= 1'b0;
	end else begin
		// a new set wins over the last clearing read
		if (set_tick)
			all_axes_avail_r <= 1'b1;
		else if (!unread_left)
			all_axes_avail_r <= 1'b0;
		if (set_tick && unread_left)
			all_axes_overrun_r <= 1'b1;
		else if (!unread_left)
			all_axes_overrun_r <= 1'b0;
	end
end

// ==========================================
// register reads
reg [7:0] rdata_nxt;
always @* begin
	case (reg_addr)
	`ACSR_OFF_IDENT: rdata_nxt = IDENT_CODE;
	`ACSR_OFF_CTRL2: rdata_nxt = {three_wire_select_r, trim_reload_r,
		1'b0, output_filter_select_r, event2_filter_enable_r,
		event1_filter_enable_r, cutoff_code_r};
	`ACSR_OFF_CTRL3: rdata_nxt = {irq_polarity_r, irq_drive_type_r,
		pin2_route_r, pin1_route_r};
	`ACSR_OFF_STATUS: rdata_nxt = {all_axes_overrun_r, z_overrun,
		y_overrun, x_overrun, all_axes_avail_r, z_avail, y_avail,
		x_avail};
	`ACSR_OFF_X_SAMPLE: rdata_nxt = x_sample_r;
	`ACSR_OFF_Y_SAMPLE: rdata_nxt = y_sample_r;
	`ACSR_OFF_Z_SAMPLE: rdata_nxt = z_sample_r;
	`ACSR_OFF_EVT1_SRC: rdata_nxt = event1_source_r;
	`ACSR_OFF_EVT2_SRC: rdata_nxt = event2_source_r;
	default: rdata_nxt = 8'h00;
	endcase
end

// read data one cycle after the strobe; dc reload is a side effect
always @(posedge clk) begin
	if (rst) begin
		reg_rdata_r <= 8'h00;
		reg_rvalid_r <= 1'b0;
		filter_dc_reload_r <= 1'b0;
	end else begin
		reg_rvalid_r <= reg_rd;
		if (reg_rd)
			reg_rdata_r <= rdata_nxt;
		filter_dc_reload_r <= reg_rd &
			(reg_addr == `ACSR_OFF_DC_RELOAD);
	end
end

// ==========================================
// serial read data steering
always @(posedge clk) begin
	if (rst) begin
		sdo_out_r <= 1'b0;
		sdo_oe_r <= 1'b0;
		sda_out_r <= 1'b0;
		sda_oe_r <= 1'b0;
	end else begin
		sdo_out_r <= ser_out_bit;
		sda_out_r <= ser_out_bit;
		sdo_oe_r <= ser_out_active & ~three_wire_select_r;
		sda_oe_r <= ser_out_active & three_wire_select_r;
	end
end

// ==========================================
// interrupt pins
acsr_irq_pin u_pin_one (
	.clk(clk),
	.rst(rst),
	.route(pin1_route_r),
	.polarity(irq_polarity_r),
	.drive_type(irq_drive_type_r),
	.evt_one(event_gen_one),
	.evt_two(event_gen_two),
	.data_ready(all_axes_avail_r),
	.pin_out_r(irq_pin_one_out),
	.pin_oe_r(irq_pin_one_oe)
);

acsr_irq_pin u_pin_two (
	.clk(clk),
	.rst(rst),
	.route(pin2_route_r),
	.polarity(irq_polarity_r),
	.drive_type(irq_drive_type_r),
	.evt_one(event_gen_one),
	.evt_two(event_gen_two),
	.data_ready(all_axes_avail_r),
	.pin_out_r(irq_pin_two_out),
	.pin_oe_r(irq_pin_two_oe)
);

endmodule
`default_nettype wire

/* dv/acsr_far_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// far side: trim store and sample front end
module acsr_far_model #(
	parameter DONE_DLY = 5
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// trim store
	input wire trim_reload_r,
	output logic trim_reload_done = 1'b0,
	// fixed samples so that stored values can be predicted
	output wire [7:0] raw_x,
	output wire [7:0] raw_y,
	output wire [7:0] raw_z,
	output wire [7:0] hp_x,
	output wire [7:0] hp_y,
	output wire [7:0] hp_z
);
	int cnt;

	// raw and filtered differ in the top bit
	assign raw_x = 8'h11;
	assign raw_y = 8'h22;
	assign raw_z = 8'h33;
	assign hp_x = 8'h91;
	assign hp_y = 8'ha2;
	assign hp_z = 8'hb3;

	// done pulse some cycles in, so the busy level is visible
	always @(posedge clk) begin
		if (rst || !trim_reload_r || trim_reload_done) begin
			cnt <= 0;
			trim_reload_done <= 1'b0;
		end else begin
			cnt <= cnt + 1;
			trim_reload_done <= (cnt == DONE_DLY - 1);
		end
	end
endmodule
`default_nettype wire

/* dv/acsr_top_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acsr_regs.vh"

// ==========================================
// checker on the top ports
module acsr_top_monitor #(
	parameter [7:0] IDENT_CODE = 8'h5a // arbitrary identifier value
) (
	// clock, reset, register port
	input wire clk,
	input wire rst,
	input wire [5:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata_r,
	input wire reg_rvalid_r,
	// control and filter
	input wire sample_rate_sel,
	input wire event1_filter_enable_r,
	input wire event2_filter_enable_r,
	input wire [1:0] cutoff_code_r,
	input wire [13:0] hp_corner_mhz_r,
	input wire filter_dc_reload_r,
	input wire trim_reload_r,
	input wire trim_reload_done,
	// serial and interrupt pads
	input wire ser_out_bit,
	input wire ser_out_active,
	input wire sdo_out_r,
	input wire sdo_oe_r,
	input wire sda_out_r,
	input wire sda_oe_r,
	input wire event_gen_one,
	input wire event_gen_two,
	input wire irq_pin_one_out,
	input wire irq_pin_one_oe,
	input wire irq_pin_two_out,
	input wire irq_pin_two_oe
);
	reg [7:0] c3_r;
	wire a1, a2, e1_oe, e2_oe, e1_out, e2_out, dcr, rl_req;
	wire [13:0] corner;

	function act(input [2:0] r, input g1, input g2);
		act = (r == 3'h1) ? g1 : (r == 3'h2) ? g2 :
			(r == 3'h3) ? (g1 | g2) : 1'b0;
	endfunction

	// shadow of control_three; ready route is not visible here
	always @(posedge clk) begin
		if (rst)
			c3_r <= 8'h00;
		else if (reg_wr && reg_addr == `ACSR_OFF_CTRL3)
			c3_r <= reg_wdata;
	end

	// expected pad levels and helper strobes
	assign a1 = act(c3_r[2:0], event_gen_one, event_gen_two);
	assign a2 = act(c3_r[5:3], event_gen_one, event_gen_two);
	assign e1_oe = (c3_r[2:0] == 3'h0) || !c3_r[6] || a1;
	assign e2_oe = (c3_r[5:3] == 3'h0) || !c3_r[6] || a2;
	assign e1_out = (c3_r[2:0] != 3'h0) && (a1 ^ c3_r[7]);
	assign e2_out = (c3_r[5:3] != 3'h0) && (a2 ^ c3_r[7]);
	assign dcr = reg_rd && reg_addr == `ACSR_OFF_DC_RELOAD;
	assign rl_req = reg_wr && reg_addr == `ACSR_OFF_CTRL2 && reg_wdata[6];
	assign corner = (sample_rate_sel ? 14'h1f40 : 14'h07d0) >> cutoff_code_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_reload_req;
		rl_req;
	endsequence
	sequence s_reload_end;
		trim_reload_r && trim_reload_done && !rl_req;
	endsequence

	property p_reload_go;
		s_reload_req |=> trim_reload_r;
	endproperty
	a_reload_go: assert property (p_reload_go)
		else $error("reload did not start");
	property p_reload_end;
		s_reload_end |=> !trim_reload_r;
	endproperty
	a_reload_end: assert property (p_reload_end)
		else $error("reload bit did not clear");
	property p_ident;
		reg_rd && reg_addr == `ACSR_OFF_IDENT |=>
			reg_rvalid_r && reg_rdata_r == IDENT_CODE;
	endproperty
	a_ident: assert property (p_ident)
		else $error("identification read wrong");
	property p_rvalid;
		1'b1 |-> reg_rvalid_r == $past(reg_rd);
	endproperty
	a_rvalid: assert property (p_rvalid)
		else $error("read valid out of step");
	property p_ser_en;
		1'b1 |=> (sdo_oe_r | sda_oe_r) == $past(ser_out_active)
			&& !(sdo_oe_r && sda_oe_r);
	endproperty
	a_ser_en: assert property (p_ser_en)
		else $error("serial pad enables wrong");
	property p_ser_dat;
		(sdo_oe_r || sda_oe_r) |->
			(sdo_oe_r ? sdo_out_r : sda_out_r) == $past(ser_out_bit);
	endproperty
	a_ser_dat: assert property (p_ser_dat)
		else $error("serial pad data wrong");
	property p_dc;
		1'b1 |-> filter_dc_reload_r == $past(dcr);
	endproperty
	a_dc: assert property (p_dc)
		else $error("filter dc reload pulse wrong");
	property p_corner;
		$stable(cutoff_code_r) && $stable(sample_rate_sel) |->
			hp_corner_mhz_r == corner;
	endproperty
	a_corner: assert property (p_corner)
		else $error("high-pass corner wrong");
	property p_pin1;
		c3_r[2:0] != 3'h4 |=> irq_pin_one_oe == $past(e1_oe)
			&& (!irq_pin_one_oe || irq_pin_one_out == $past(e1_out));
	endproperty
	a_pin1: assert property (p_pin1)
		else $error("interrupt pin one wrong");
	property p_pin2;
		c3_r[5:3] != 3'h4 |=> irq_pin_two_oe == $past(e2_oe)
			&& (!irq_pin_two_oe || irq_pin_two_out == $past(e2_out));
	endproperty
	a_pin2: assert property (p_pin2)
		else $error("interrupt pin two wrong");
	property p_rst;
		$fell(rst) |-> irq_pin_one_oe && !irq_pin_one_out && irq_pin_two_oe
			&& cutoff_code_r == 2'h0 && !event1_filter_enable_r
			&& !event2_filter_enable_r && !trim_reload_r;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset state wrong");
endmodule

bind acsr_top acsr_top_monitor #(.IDENT_CODE(IDENT_CODE)) u_mon (.*);
`default_nettype wire

/* dv/tb_accel_control_status_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acsr_regs.vh"

// ==========================================
// bench for the control and status registers
module tb_accel_control_status_regs;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [5:0] reg_addr = 6'h00;
	logic [7:0] reg_wdata = 8'h00, event1_flags = 8'h00, event2_flags = 8'h00;
	logic sample_rate_sel = 1'b0, x_en = 1'b1, y_en = 1'b1, z_en = 1'b0;
	logic event_gen_one = 1'b0, event_gen_two = 1'b0;
	logic ser_out_bit = 1'b0, ser_out_active = 1'b0;
	wire [7:0] reg_rdata_r, raw_x, raw_y, raw_z, hp_x, hp_y, hp_z;
	wire reg_rvalid_r, event1_filter_enable_r, event2_filter_enable_r;
	wire filter_dc_reload_r, trim_reload_r, trim_reload_done, sample_tick_r;
	wire sdo_out_r, sdo_oe_r, sda_out_r, sda_oe_r;
	wire irq_pin_one_out, irq_pin_one_oe, irq_pin_two_out, irq_pin_two_oe;
	wire [1:0] cutoff_code_r;
	wire [13:0] hp_corner_mhz_r;
	int error_cnt = 0, n_checks = 0, i, n;
	logic [7:0] d;
	logic a, eo;

	always #10 clk = ~clk;

	// short sample periods keep the run small
	acsr_top #(.SLOW_CYCLES(40), .FAST_CYCLES(10)) uut (.*);
	acsr_far_model far (.*);

	task cyc;
		@(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input logic [5:0] ad, input logic [7:0] v);
		cyc;
		reg_addr = ad;
		reg_wdata = v;
		reg_wr = 1'b1;
		cyc;
		reg_wr = 1'b0;
	endtask
	// strobe is taken at the edge, data stands the cycle after
	task rdc(input logic [5:0] ad, input logic [7:0] e);
		cyc;
		reg_addr = ad;
		reg_rd = 1'b1;
		cyc;
		reg_rd = 1'b0;
		chk("rvalid", 8'h01, {7'h00, reg_rvalid_r});
		chk($sformatf("reg %h", ad), e, reg_rdata_r);
	endtask
	task wait_tick;
		for (int k = 0; k < 100 && sample_tick_r !== 1'b1; k++)
			cyc;
		chk("tick", 8'h01, {7'h00, sample_tick_r});
	endtask
	task period(input logic [7:0] e);
		wait_tick;
		n = 0;
		do begin
			cyc;
			n++;
		end while (sample_tick_r !== 1'b1 && n < 200);
		chk("period", e, n[7:0]);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog, well past the expected run length
	initial begin
		#200000;
		error_cnt++;
		report_and_stop;
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		rdc(`ACSR_OFF_CTRL2, 8'h00);
		rdc(`ACSR_OFF_CTRL3, 8'h00);
		wr(`ACSR_OFF_IDENT, 8'hff);
		rdc(`ACSR_OFF_IDENT, 8'h5a);
		rdc(6'h3f, 8'h00);
		wr(`ACSR_OFF_CTRL2, 8'h9f);
		rdc(`ACSR_OFF_CTRL2, 8'h9f);
		chk("evt filt", 8'h03, {6'h00, event2_filter_enable_r,
			event1_filter_enable_r});
		ser_out_active = 1'b1;
		ser_out_bit = 1'b1;
		cyc;
		cyc;
		chk("3w pads", 8'h03, {5'h00, sdo_oe_r, sda_oe_r, sda_out_r});
		wr(`ACSR_OFF_CTRL2, 8'h00);
		ser_out_bit = 1'b0;
		cyc;
		cyc;
		chk("4w pads", 8'h04, {5'h00, sdo_oe_r, sda_oe_r, sdo_out_r});
		ser_out_active = 1'b0;
		// every cut-off code at both rates
		for (i = 0; i < 8; i++) begin
			sample_rate_sel = i[2];
			wr(`ACSR_OFF_CTRL2, {6'h00, i[1:0]});
			cyc;
			chk("cutoff", {6'h00, i[1:0]}, {6'h00, cutoff_code_r});
		end
		sample_rate_sel = 1'b0;
		wr(`ACSR_OFF_CTRL2, 8'h40);
		chk("reload", 8'h01, {7'h00, trim_reload_r});
		for (i = 0; i < 50 && trim_reload_r === 1'b1; i++)
			cyc;
		rdc(`ACSR_OFF_CTRL2, 8'h00);
		// flags; z stays disabled throughout
		event1_flags = 8'h5c;
		event2_flags = 8'ha3;
		wait_tick;
		rdc(`ACSR_OFF_X_SAMPLE, 8'h11);
		rdc(`ACSR_OFF_Y_SAMPLE, 8'h22);
		rdc(`ACSR_OFF_STATUS, 8'h00);
		wait_tick;
		rdc(`ACSR_OFF_STATUS, 8'h0b);
		rdc(`ACSR_OFF_X_SAMPLE, 8'h11);
		rdc(`ACSR_OFF_STATUS, 8'h0a);
		wait_tick;
		rdc(`ACSR_OFF_STATUS, 8'hab);
		rdc(`ACSR_OFF_Y_SAMPLE, 8'h22);
		rdc(`ACSR_OFF_STATUS, 8'h89);
		rdc(`ACSR_OFF_X_SAMPLE, 8'h11);
		rdc(`ACSR_OFF_STATUS, 8'h00);
		rdc(`ACSR_OFF_EVT1_SRC, 8'h5c);
		rdc(`ACSR_OFF_EVT2_SRC, 8'ha3);
		wr(`ACSR_OFF_CTRL2, 8'h10);
		wait_tick;
		rdc(`ACSR_OFF_X_SAMPLE, 8'h91);
		rdc(`ACSR_OFF_DC_RELOAD, 8'h00);
		period(8'd40);
		sample_rate_sel = 1'b1;
		wait_tick;
		period(8'd10);
		// routes, polarity, drive type and sources
		for (i = 0; i < 128; i++) begin
			event_gen_one = i[0];
			event_gen_two = i[1];
			wr(`ACSR_OFF_CTRL3, {i[6:5], i[4:2], i[4:2]});
			cyc;
			cyc;
			a = (i[4:2] == 1) ? i[0] : (i[4:2] == 2) ? i[1] :
				(i[4:2] == 3) ? (i[0] | i[1]) : 1'b0;
			// ground route drives low whatever polarity and drive type
			eo = (i[4:2] == 0) | ~i[5] | a;
			a = (i[4:2] != 0) & (a ^ i[6]);
			if (i[4:2] != 4) begin
				chk("irq pin", {6'h00, eo, eo & a}, {6'h00, irq_pin_one_oe,
					irq_pin_one_oe & irq_pin_one_out});
				chk("irq pin2", {6'h00, eo, eo & a}, {6'h00, irq_pin_two_oe,
					irq_pin_two_oe & irq_pin_two_out});
			end
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
